//--- hw/asr_pkg.sv
package asr_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 20;
    localparam int PROBE_DELAY_NS = 500;
    localparam int PROBE_CYC      = (PROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS    = 100;
    localparam int SCK_HALF_CYC   = (SCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1
                                    : SCK_HALF_NS / CLK_PERIOD_NS;

    // ****************************************
    // frame and settings word
    // ****************************************
    localparam int         FRAME_BITS    = 32;
    localparam int         CFG_BITS      = 13;
    localparam logic [5:0] N_FRAME       = 6'h20;
    localparam logic [5:0] N_CFG         = 6'h0D;
    localparam int         PREFIX_MSB    = 12;
    localparam int         PREFIX_LSB    = 10;
    localparam int         CHAN_MSB      = 9;
    localparam int         CHAN_LSB      = 5;
    localparam int         SPEED_MSB     = 4;
    localparam int         SPEED_LSB     = 0;
    localparam logic [2:0] PREFIX_UPDATE = 3'h5;
    localparam logic [4:0] SPEED_KEEP    = 5'h00;
    localparam logic [4:0] CHAN_RST      = 5'h00;
    localparam logic [4:0] SPEED_RST     = 5'h00;
    localparam logic [5:0] SYNC_RST      = 6'h30;

    typedef enum logic [3:0] {
        ST_BOOT  = 4'h1,
        ST_CONV  = 4'h2,
        ST_SLEEP = 4'h4,
        ST_READ  = 4'h8
    } asr_state_t;

endpackage

//--- hw/asr_sync2.sv
module asr_sync2 #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST;
            q    <= RST;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

//--- hw/asr_result_port.sv
// Overview of operation
// - select pin low: external clock, high: internal
// - data out released while chip select high
// - chip select low shows done flag, busy
// - sleep entered automatically when conversion ends
// - result loaded at flag fall, held asleep
// - external: wait first rise, shift on falls
// - flag at rise one, last bit rise 32
// - external: 32nd fall starts conversion, flag high
// - external: chip select rise aborts, restarts conversion
// - abort before 13th rise keeps old settings
// - works with chip select tied low
// - internal: select fall drives clock low
// - internal: busy low until result read
// - internal: clock starts 500ns after flag/select
// - internal: early select rise keeps sleeping
// - internal: generated clock driven, shift on falls
// - internal: after 32nd rise, flag, clock high
// - internal: select rise mid frame aborts, restarts
// - prefix 101 updates channel, and speed unless speed field is 0
// - busy rises when new conversion begins
module asr_result_port #(
    parameter int PROBE_CYC = asr_pkg::PROBE_CYC,
    parameter int SCK_HALF  = asr_pkg::SCK_HALF_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        sck_link,
    input  wire logic        clock_source_select_n,
    input  wire logic        cs_n,
    input  wire logic        sdi,
    input  wire logic        conv_done,
    input  wire logic [30:0] conv_result,
    output logic             conv_start,
    output logic             busy,
    output logic             sck_out,
    output logic             sck_oe,
    output logic             sdo_out,
    output logic             sdo_oe,
    output logic [4:0]       chan_sel,
    output logic [4:0]       speed_sel
);

    localparam int PW = $clog2(PROBE_CYC + 1);
    localparam int HW = $clog2(SCK_HALF + 1);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic frame_bit(input logic [31:0] f, input logic [5:0] k);
        frame_bit = f[5'(6'h1F - k)];
    endfunction

    function automatic logic [9:0] apply_cfg(input logic [12:0] w,
                                             input logic [4:0]  ch,
                                             input logic [4:0]  sp);
        logic [4:0] new_sp;
        new_sp = w[asr_pkg::SPEED_MSB:asr_pkg::SPEED_LSB];
        if (w[asr_pkg::PREFIX_MSB:asr_pkg::PREFIX_LSB] == asr_pkg::PREFIX_UPDATE) begin
            apply_cfg = {w[asr_pkg::CHAN_MSB:asr_pkg::CHAN_LSB],
                         (new_sp == asr_pkg::SPEED_KEEP) ? sp : new_sp};
        end else begin
            apply_cfg = {ch, sp};
        end
    endfunction

    // ****************************************
    // declarations
    // ****************************************
    asr_pkg::asr_state_t st;
    asr_pkg::asr_state_t next_st;

    logic        cs_s;
    logic        sel_s;
    logic        sdi_s;
    logic        started_s;
    logic        done_s;
    logic        cfgok_s;
    logic        cs_d;
    logic        armed;
    logic [31:0] frame;
    logic [PW-1:0] pcnt;
    logic [HW-1:0] hcnt;
    logic [5:0]  rc;
    logic [12:0] cfg_int;
    logic        cfg_int_ok;
    logic        sdo_int;
    logic        go_conv;

    logic [5:0]  rcnt;
    logic [5:0]  fcnt;
    logic [12:0] lk_cfg;
    logic        lk_cfg_ok;
    logic        lk_started;
    logic        lk_bit;
    logic        lk_done;

    // ****************************************
    // pin and link flag synchronisers
    // ****************************************
    asr_sync2 #(
        .W   (6),
        .RST (asr_pkg::SYNC_RST)
    ) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({cs_n, clock_source_select_n, sdi, lk_started, lk_done, lk_cfg_ok}),
        .q     ({cs_s, sel_s, sdi_s, started_s, done_s, cfgok_s})
    );

    wire ext_s    = ~sel_s;
    wire cs_rise  = cs_s & ~cs_d;
    wire cs_fall  = ~cs_s & cs_d;
    wire st_conv  = (st == asr_pkg::ST_CONV);
    wire st_sleep = (st == asr_pkg::ST_SLEEP);
    wire st_read  = (st == asr_pkg::ST_READ);

    // ****************************************
    // internal clock sequencing
    // ****************************************
    wire slp_lo    = st_sleep & ~cs_s;
    wire probe_hit = ~ext_s & slp_lo & (pcnt == PW'(PROBE_CYC - 1));
    wire half_hit  = (hcnt == HW'(SCK_HALF - 1));
    wire int_rise  = ~ext_s & (probe_hit | (st_read & half_hit & ~sck_out));
    wire int_fall  = ~ext_s & st_read & half_hit & sck_out & (rc != asr_pkg::N_FRAME);
    wire int_end   = st_read & half_hit & sck_out & (rc == asr_pkg::N_FRAME);
    wire ext_end   = started_s & done_s;
    wire enter_slp = st_conv & conv_done;

    // ****************************************
    // state machine
    // ****************************************
    always_comb begin
        next_st = st;
        go_conv = 1'b0;
        unique case (st)
            asr_pkg::ST_BOOT: begin
                go_conv = 1'b1;
            end
            asr_pkg::ST_CONV: begin
                if (conv_done) begin
                    next_st = asr_pkg::ST_SLEEP;
                end
            end
            asr_pkg::ST_SLEEP: begin
                // early select rise just keeps the sleep state
                if (ext_s ? started_s : probe_hit) begin
                    next_st = asr_pkg::ST_READ;
                end
            end
            asr_pkg::ST_READ: begin
                if (cs_rise | (ext_s ? ext_end : int_end)) begin
                    go_conv = 1'b1;
                end
            end
        endcase
        if (go_conv) begin
            next_st = asr_pkg::ST_CONV;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st         <= asr_pkg::ST_BOOT;
            cs_d       <= 1'b1;
            armed      <= 1'b0;
            conv_start <= 1'b0;
            busy       <= 1'b0;
            sck_oe     <= 1'b0;
            sdo_oe     <= 1'b0;
        end else begin
            st         <= next_st;
            cs_d       <= cs_s;
            // link logic is held cleared outside sleep and readout
            armed      <= ext_s & (next_st != asr_pkg::ST_CONV)
                               & (next_st != asr_pkg::ST_BOOT);
            conv_start <= go_conv;
            busy       <= (next_st == asr_pkg::ST_CONV);
            sck_oe     <= ~ext_s;
            sdo_oe     <= ~cs_s;
        end
    end

    // ****************************************
    // result, settings and probe delay counter
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame     <= '0;
            chan_sel  <= asr_pkg::CHAN_RST;
            speed_sel <= asr_pkg::SPEED_RST;
        end else begin
            if (enter_slp) begin
                frame <= {1'b0, conv_result};
            end
            // frames cut before the 13th rise leave the previous settings in place
            if (st_read & go_conv & ext_s & cfgok_s) begin
                {chan_sel, speed_sel} <= apply_cfg(lk_cfg, chan_sel, speed_sel);
            end else if (st_read & go_conv & ~ext_s & cfg_int_ok) begin
                {chan_sel, speed_sel} <= apply_cfg(cfg_int, chan_sel, speed_sel);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt <= '0;
        end else if (slp_lo & ~ext_s & ~probe_hit) begin
            pcnt <= pcnt + PW'(1);
        end else begin
            pcnt <= '0;
        end
    end

    // ****************************************
    // internal clock generator and shifter
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_out    <= 1'b1;
            sdo_int    <= 1'b1;
            hcnt       <= '0;
            rc         <= '0;
            cfg_int    <= '0;
            cfg_int_ok <= 1'b0;
        end else if (go_conv) begin
            sck_out <= 1'b1;
            sdo_int <= 1'b1;
        end else if (cs_fall & ~ext_s) begin
            sck_out <= 1'b0;
        end else if (enter_slp) begin
            // clock drops with the flag, so the first rise is a real edge
            sck_out <= 1'b0;
            sdo_int <= 1'b0;
        end else if (int_rise) begin
            sck_out <= 1'b1;
            hcnt    <= '0;
            rc      <= st_sleep ? 6'h01 : rc + 6'h01;
            if (st_sleep | (rc < asr_pkg::N_CFG)) begin
                cfg_int <= {cfg_int[11:0], sdi_s};
            end
            cfg_int_ok <= ~st_sleep & (cfg_int_ok | (rc == asr_pkg::N_CFG - 6'h01));
        end else if (int_fall) begin
            sck_out <= 1'b0;
            hcnt    <= '0;
            sdo_int <= frame_bit(frame, rc);
        end else if (st_read & ~ext_s) begin
            hcnt <= hcnt + HW'(1);
        end
    end

    // ****************************************
    // external link clock domain
    // ****************************************
    // armed is a clean flop, so the link side is cleared glitch free
    always_ff @(posedge sck_link or negedge armed) begin
        if (!armed) begin
            rcnt       <= '0;
            lk_cfg     <= '0;
            lk_cfg_ok  <= 1'b0;
            lk_started <= 1'b0;
        end else begin
            lk_started <= 1'b1;
            if (rcnt != asr_pkg::N_FRAME) begin
                rcnt <= rcnt + 6'h01;
            end
            if (rcnt < asr_pkg::N_CFG) begin
                lk_cfg <= {lk_cfg[11:0], sdi};
            end
            if (rcnt == asr_pkg::N_CFG - 6'h01) begin
                lk_cfg_ok <= 1'b1;
            end
        end
    end

    always_ff @(negedge sck_link or negedge armed) begin
        if (!armed) begin
            fcnt    <= '0;
            lk_bit  <= 1'b0;
            lk_done <= 1'b0;
        end else if (!lk_done) begin
            fcnt <= fcnt + 6'h01;
            if (fcnt == asr_pkg::N_FRAME - 6'h01) begin
                lk_bit  <= 1'b1;
                lk_done <= 1'b1;
            end else begin
                lk_bit <= frame_bit(frame, fcnt + 6'h01);
            end
        end
    end

    // external data must change on the link's own falling edge, so no retime here
    assign sdo_out = ext_s ? (armed ? lk_bit : 1'b1) : sdo_int;

    // ****************************************
    // assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SDO_RELEASE: assert property ($rose(cs_s) |=> !sdo_oe)
        else $error("data out still driven with chip select high");
    AST_FLAG_CONV: assert property (st_conv |-> sdo_out && busy)
        else $error("flag or busy low while converting");
    AST_AUTO_SLEEP: assert property (enter_slp |=> st_sleep && !busy)
        else $error("no sleep after conversion done");
    AST_LOAD: assert property (enter_slp |=> frame == {1'b0, $past(conv_result)})
        else $error("result not loaded at flag fall");
    AST_HOLD: assert property (st_sleep && $past(st_sleep) |-> $stable(frame))
        else $error("result changed during sleep");
    AST_EXT_END: assert property (ext_s && st_read && ext_end |=> st_conv && busy ##1 conv_start == 1'b0)
        else $error("no conversion after external frame");
    AST_ABORT: assert property (st_read && cs_rise |=> st_conv ##0 $past(conv_start) == 1'b0 ##0 conv_start)
        else $error("abort did not restart conversion");
    AST_PROBE: assert property (!ext_s && $rose(st_read) |-> sck_out && $past(slp_lo, 25))
        else $error("internal clock started before probe delay");
    AST_SCK_LOW: assert property (!ext_s && cs_fall && !go_conv |=> !sck_out)
        else $error("clock not low after select fall");
    AST_INT_END: assert property (!ext_s && st_read && int_end |=> sck_out && sdo_out && busy)
        else $error("frame end without flag and clock high");
    AST_EARLY_CS: assert property (!ext_s && st_sleep && cs_s |=> st_sleep)
        else $error("left sleep with chip select high");
    AST_CFG: assert property ($changed(chan_sel) |-> $past(st_read) && st_conv)
        else $error("settings changed outside frame end");

endmodule

//--- bench/asr_host_model.sv
module asr_host_model (
    input  wire logic clk,
    input  wire logic sck_pin,
    input  wire logic sdo_w,
    output logic      cs_n,
    output logic      sck_link,
    output logic      sdi
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n = 1'b1;
        sck_link = 1'b0;
        sdi = 1'b0;
    end

    task automatic set_cs(input logic v);
        @(negedge clk);
        cs_n = v;
    endtask

    // ****
    // external clock frame; clock idles low between frames
    // ****
    task automatic ext_frame(input int nb, input logic [12:0] w, output logic [31:0] got);
        got = '0;
        if (cs_n) begin
            set_cs(1'b0);
            repeat (4) @(negedge clk);
        end
        for (int k = 0; k < nb; k++) begin
            sdi = (k < 13) ? w[12-k] : 1'b0;
            #16 sck_link = 1'b1;
            got = {got[30:0], sdo_w};
            #16 sck_link = 1'b0;
        end
        sdi = ~sdi;
        if (nb < 32) set_cs(1'b1);
    endtask

    // ****
    // internal clock frame; counts clk edges until the first rise
    // ****
    task automatic int_read(input int nb, output int n, output logic [31:0] got);
        n = 0;
        got = '0;
        while (sck_pin !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        for (int k = 0; k < nb; k++) begin
            if (k > 0) @(posedge sck_pin);
            #1 got = {got[30:0], sdo_w};
        end
        if (nb < 32) set_cs(1'b1);
    endtask
endmodule

//--- bench/asr_result_port_tb.sv
module asr_result_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_n;
    logic        sel_n;
    logic        conv_done;
    logic [30:0] conv_result;
    logic [30:0] held;
    logic        conv_start, busy, sck_out, sck_oe, sdo_out, sdo_oe, cs_n, host_sck, sdi;
    logic [4:0]  chan_sel, speed_sel;
    logic [31:0] got;
    int          n, n_errors, compares;
    wire         sck_pin = sck_oe ? sck_out : host_sck;
    wire         sdo_w   = sdo_oe ? sdo_out : 1'bz;

    asr_result_port asr_result_port_i (
        .clk(clk), .rst_n(rst_n), .sck_link(sck_pin), .clock_source_select_n(sel_n),
        .cs_n(cs_n), .sdi(sdi), .conv_done(conv_done), .conv_result(conv_result),
        .conv_start(conv_start), .busy(busy), .sck_out(sck_out), .sck_oe(sck_oe),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .chan_sel(chan_sel), .speed_sel(speed_sel)
    );

    asr_host_model asr_host_model_i (
        .clk(clk), .sck_pin(sck_pin), .sdo_w(sdo_w),
        .cs_n(cs_n), .sck_link(host_sck), .sdi(sdi)
    );

    always #10 clk = ~clk;

    // converter stand-in: one result per start pulse
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            repeat (20) @(negedge clk);
            conv_result = conv_result + 31'h0123457;
            held = conv_result;
            conv_done = 1'b1;
            @(negedge clk);
            conv_done = 1'b0;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // bounded wait for busy to reach a level
    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 200 && busy !== lvl; i++) @(negedge clk);
        check("busy", 32'(busy), 32'(lvl));
    endtask

    task automatic check_cfg(input logic [4:0] ch, input logic [4:0] sp);
        repeat (8) @(negedge clk);
        check("chan", 32'(chan_sel), 32'(ch));
        check("speed", 32'(speed_sel), 32'(sp));
    endtask

    initial begin
        #500000;
        n_errors++;
        print_verdict();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sel_n = 1'b0;
        conv_done = 1'b0;
        conv_result = 31'h2AAA5555;
        held = '0;
        n_errors = 0;
        compares = 0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check("busy boot", 32'(busy), 32'h1);
        check("sdo oe idle", 32'(sdo_oe), 32'h0);
        wait_busy(1'b0);
        check_cfg(5'h00, 5'h00);
        asr_host_model_i.set_cs(1'b0);
        repeat (4) @(negedge clk);
        check("sdo oe", 32'(sdo_oe), 32'h1);
        check("flag sleep", 32'(sdo_w), 32'h0);
        asr_host_model_i.ext_frame(32, {3'h5, 5'h0A, 5'h13}, got);
        check("ext frame", got, {1'b0, held});
        #2;
        check("sdo end", 32'(sdo_w), 32'h1);
        wait_busy(1'b1);
        check("conv start", 32'(conv_start), 32'h1);
        check_cfg(5'h0A, 5'h13);
        check("flag conv", 32'(sdo_w), 32'h1);
        wait_busy(1'b0);
        check("flag done", 32'(sdo_w), 32'h0);
        asr_host_model_i.ext_frame(32, {3'h5, 5'h03, 5'h00}, got);
        check_cfg(5'h03, 5'h13);
        wait_busy(1'b0);
        asr_host_model_i.ext_frame(10, {3'h5, 5'h1F, 5'h1F}, got);
        check("ext part", got, 32'({1'b0, held[30:22]}));
        wait_busy(1'b1);
        check("sdo oe abort", 32'(sdo_oe), 32'h0);
        check_cfg(5'h03, 5'h13);
        wait_busy(1'b0);
        asr_host_model_i.ext_frame(32, {3'h4, 5'h1F, 5'h1F}, got);
        check_cfg(5'h03, 5'h13);
        wait_busy(1'b0);
        asr_host_model_i.ext_frame(16, {3'h5, 5'h07, 5'h11}, got);
        wait_busy(1'b1);
        check_cfg(5'h07, 5'h11);
        asr_host_model_i.set_cs(1'b1);
        sel_n = 1'b1;
        wait_busy(1'b0);
        asr_host_model_i.set_cs(1'b0);
        repeat (8) @(negedge clk);
        asr_host_model_i.set_cs(1'b1);
        repeat (40) @(negedge clk);
        check("busy early cs", 32'(busy), 32'h0);
        asr_host_model_i.set_cs(1'b0);
        repeat (4) @(negedge clk);
        check("sck low", 32'(sck_pin), 32'h0);
        check("sck oe", 32'(sck_oe), 32'h1);
        asr_host_model_i.int_read(32, n, got);
        check("probe", 32'(n + 4 >= 25 && n + 4 <= 31), 32'h1);
        check("int frame", got, {1'b0, held});
        wait_busy(1'b1);
        check("sdo int end", 32'(sdo_w), 32'h1);
        check("sck int end", 32'(sck_pin), 32'h1);
        check_cfg(5'h07, 5'h11);
        wait_busy(1'b0);
        asr_host_model_i.int_read(6, n, got);
        check("int part", got, 32'({1'b0, held[30:26]}));
        wait_busy(1'b1);
        print_verdict();
    end
endmodule
